// File: src/gfs_supervisor.sv
`timescale 1ns/1ps
module gfs_supervisor (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  opt_gate,
  input  wire logic        decode_mode,
  input  wire logic        short_on_fault,
  input  wire logic [11:0] cur_mag,
  input  wire logic [11:0] vdc_up,
  input  wire logic [11:0] vdc_low,
  input  wire logic [11:0] temp,
  input  wire logic [11:0] sup_5v,
  input  wire logic        ack_btn,
  output logic      [3:0]  gate_q,
  output logic      [3:0]  fault_flags_q,
  output logic             error_n_q
);
  logic [8:0]  fast_cnt_q;
  logic [15:0] slow_cnt_q;
  logic        fast_en_q;
  logic        slow_en_q;
  logic        ack_q;
  wire  logic [3:0] fast_hit;
  wire  logic [3:0] slow_hit;
  wire  logic [3:0] hits;
  wire  logic [3:0] flags_d;
  wire  logic       ack_rise;
  wire  logic [3:0] decoded;
  wire  logic [3:0] normal_gate;
  wire  logic [3:0] fault_gate;
  wire  logic       short_ok;

  function automatic logic [3:0] gfs_decode(input logic [1:0] st);
    case (gfs_pkg::gfs_state_t'(st))
      gfs_pkg::GFS_ST_P: gfs_decode = 4'h3;
      gfs_pkg::GFS_ST_O: gfs_decode = 4'h6;
      gfs_pkg::GFS_ST_N: gfs_decode = 4'hC;
      default:           gfs_decode = 4'h0;
    endcase
  endfunction

  // sample rate enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_q <= 9'h000;
      fast_en_q  <= 1'b0;
    end else begin
      fast_en_q  <= (fast_cnt_q == gfs_pkg::FAST_DIV_LAST);
      fast_cnt_q <= (fast_cnt_q == gfs_pkg::FAST_DIV_LAST) ? 9'h000 : fast_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_q <= 16'h0000;
      slow_en_q  <= 1'b0;
    end else begin
      slow_en_q  <= (slow_cnt_q == gfs_pkg::SLOW_DIV_LAST);
      slow_cnt_q <= (slow_cnt_q == gfs_pkg::SLOW_DIV_LAST) ? 16'h0000 : slow_cnt_q + 16'h0001;
    end
  end

  // fast sampler: current and voltage
  gfs_sampler u_fast_sampler (
    .clk       (clk),
    .rst_n     (rst_n),
    .sample_en (fast_en_q),
    .cur_mag   (cur_mag),
    .vdc_up    (vdc_up),
    .vdc_low   (vdc_low),
    .temp      (12'h000),
    .sup_5v    (gfs_pkg::SUP_LOW),
    .hit_q     (fast_hit)
  );

  // slow sampler: temperature and supply
  gfs_sampler u_slow_sampler (
    .clk       (clk),
    .rst_n     (rst_n),
    .sample_en (slow_en_q),
    .cur_mag   (12'h000),
    .vdc_up    (12'h000),
    .vdc_low   (12'h000),
    .temp      (temp),
    .sup_5v    (sup_5v),
    .hit_q     (slow_hit)
  );

  assign hits     = fast_hit | slow_hit;
  assign ack_rise = ack_btn & ~ack_q;

  // acknowledge edge detect, idles low like the button
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_btn;
    end
  end

  // one latch per flag; set wins over acknowledge
  for (genvar f = 0; f < 4; f++) begin : g_flag
    assign flags_d[f] = hits[f] | (~ack_rise & fault_flags_q[f]);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fault_flags_q[f] <= gfs_pkg::FLAGS_RESET[f];
      end else begin
        fault_flags_q[f] <= flags_d[f];
      end
    end
  end

  // global error line, low while any flag stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_n_q <= 1'b1;
    end else begin
      error_n_q <= ~(|flags_d);
    end
  end

  assign decoded     = gfs_decode(opt_gate[1:0]);
  assign normal_gate = decode_mode ? decoded : opt_gate;
  // short circuit only for voltage/temperature/supply causes, never overcurrent
  assign short_ok    = short_on_fault & ~flags_d[gfs_pkg::FLAG_CUR];
  assign fault_gate  = short_ok ? gfs_pkg::GATE_SHORT : gfs_pkg::GATE_BLOCKED;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= gfs_pkg::GATE_BLOCKED;
    end else begin
      gate_q <= (|flags_d) ? fault_gate : normal_gate;
    end
  end
endmodule

// File: src/gfs_pkg.sv
// Behaviour
// - default mode drives each gate output straight from its optical input.
// - gates derive from optical commands; optional mode decodes a switching state.
// - fault overrides commands with blocked or short-circuit state per config and cause.
// - fault flag outputs reflect latched fast and slow sampler indications.
// - global error output is high normally, low as soon as any fault.
// - tripped fault clears only on manual push-button acknowledge.
// - fast sampler checks voltage and current at about 150 ksps against thresholds.
// - slow sampler flags temperature or supply out of range at 1 ksps.
// - default trips: current above 30 A, half-bus above 450 V, heatsink above 90 C.
// - supply fault when 5 V rail below 4.5 V or above 5.5 V.
package gfs_pkg;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned FAST_SPS       = 150000;
  localparam int unsigned FAST_DIV       = CLK_HZ / FAST_SPS;
  localparam logic [8:0]  FAST_DIV_LAST  = 9'(FAST_DIV - 1);
  localparam int unsigned SLOW_SPS       = 1000;
  localparam int unsigned SLOW_DIV       = CLK_HZ / SLOW_SPS;
  localparam logic [15:0] SLOW_DIV_LAST  = 16'(SLOW_DIV - 1);
  // thresholds in sampler units: 0.1 A, 1 V, 1 C, 10 mV
  localparam logic [11:0] I_LIMIT        = 12'h12C;
  localparam logic [11:0] V_LIMIT        = 12'h1C2;
  localparam logic [11:0] T_LIMIT        = 12'h05A;
  localparam logic [11:0] SUP_LOW        = 12'h1C2;
  localparam logic [11:0] SUP_HIGH       = 12'h226;
  localparam logic [3:0]  GATE_BLOCKED   = 4'h0;
  localparam logic [3:0]  GATE_SHORT     = 4'hF;
  localparam logic [3:0]  FLAGS_RESET    = 4'h0;
  localparam int unsigned FLAG_CUR       = 0;
  localparam int unsigned FLAG_VOLT      = 1;
  localparam int unsigned FLAG_TEMP      = 2;
  localparam int unsigned FLAG_SUP       = 3;
  typedef enum logic [1:0] {GFS_ST_P, GFS_ST_O, GFS_ST_N, GFS_ST_OFF} gfs_state_t;
endpackage

// File: src/gfs_sampler.sv
`timescale 1ns/1ps
module gfs_sampler (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sample_en,
  input  wire logic [11:0] cur_mag,
  input  wire logic [11:0] vdc_up,
  input  wire logic [11:0] vdc_low,
  input  wire logic [11:0] temp,
  input  wire logic [11:0] sup_5v,
  output logic      [3:0]  hit_q
);
  wire logic [3:0] hit_d;
  assign hit_d[gfs_pkg::FLAG_CUR]  = cur_mag > gfs_pkg::I_LIMIT;
  assign hit_d[gfs_pkg::FLAG_VOLT] = (vdc_up > gfs_pkg::V_LIMIT) || (vdc_low > gfs_pkg::V_LIMIT);
  assign hit_d[gfs_pkg::FLAG_TEMP] = temp > gfs_pkg::T_LIMIT;
  assign hit_d[gfs_pkg::FLAG_SUP]  = (sup_5v < gfs_pkg::SUP_LOW) || (sup_5v > gfs_pkg::SUP_HIGH);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= gfs_pkg::FLAGS_RESET;
    end else if (sample_en) begin
      hit_q <= hit_d;
    end
  end
endmodule

// File: verif/gfs_monitor.sv
`timescale 1ns/1ps
module gfs_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  opt_gate,
  input wire logic        decode_mode,
  input wire logic        short_on_fault,
  input wire logic [11:0] cur_mag,
  input wire logic [11:0] vdc_up,
  input wire logic [11:0] vdc_low,
  input wire logic        ack_btn,
  input wire logic [3:0]  gate_q,
  input wire logic [3:0]  fault_flags_q,
  input wire logic        error_n_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_err_flags: assert property (error_n_q == (fault_flags_q == 4'h0))
    else $error("error line disagrees with flags");
  chk_pass_thru: assert property (error_n_q && !$past(decode_mode) |-> gate_q == $past(opt_gate))
    else $error("gate not passed through");
  chk_fault_blocked: assert property (!error_n_q && !short_on_fault && !$past(short_on_fault)
    |-> gate_q == gfs_pkg::GATE_BLOCKED)
    else $error("gate not blocked on fault");
  chk_fault_short: assert property (!error_n_q && short_on_fault && $past(short_on_fault) && !fault_flags_q[0]
    |-> gate_q == gfs_pkg::GATE_SHORT)
    else $error("gate not shorted on fault");
  chk_latch_hold: assert property (!error_n_q && !$rose(ack_btn) |=> !error_n_q)
    else $error("error released without acknowledge");
  chk_flags_hold: assert property (!$rose(ack_btn) |=> (fault_flags_q & $past(fault_flags_q)) == $past(fault_flags_q))
    else $error("flag dropped without acknowledge");
  chk_cur_trip: assert property ((cur_mag > gfs_pkg::I_LIMIT) [*8] |-> ##[0:340] fault_flags_q[0])
    else $error("current fault missed");
  chk_volt_trip: assert property ((vdc_up > gfs_pkg::V_LIMIT) [*8] |-> ##[0:340] fault_flags_q[1])
    else $error("voltage fault missed");
  chk_vlow_trip: assert property ((vdc_low > gfs_pkg::V_LIMIT) [*8] |-> ##[0:340] fault_flags_q[1])
    else $error("lower half-bus fault missed");
endmodule
bind gfs_supervisor gfs_monitor mon_u (.*);

// File: verif/gfs_master.sv
`timescale 1ns/1ps
module gfs_master (
  input  wire logic       clk,
  input  wire logic [3:0] cmd,
  input  wire logic       press,
  output logic      [3:0] opt_gate = 4'h0,
  output logic            ack_btn  = 1'b0
);
  always @(posedge clk) begin
    opt_gate <= cmd;
    ack_btn  <= press;
  end
endmodule

// File: verif/gfs_supervisor_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t %h %h", $time, a, b); end end
module gfs_supervisor_bench;
  logic clk = 0, rst_n = 0, dm = 0, sh = 0, press = 0, ack, err;
  logic [3:0] cmd = 4'h0, opt, gate, flags;
  logic [11:0] cur = 12'h000, vup = 12'h000, vlo = 12'h000, tmp = 12'h019, sup = 12'h1F4;
  logic [8:0] rows [8] = '{9'h055, 9'h0AA, 9'h0FF, 9'h000, 9'h103, 9'h116, 9'h12C, 9'h130};
  int n_mismatch = 0, checks = 0;
  always #10 clk = ~clk;
  gfs_master ptn_u (.clk(clk), .cmd(cmd), .press(press), .opt_gate(opt), .ack_btn(ack));
  gfs_supervisor dut_u (.clk(clk), .rst_n(rst_n), .opt_gate(opt), .decode_mode(dm), .short_on_fault(sh),
    .cur_mag(cur), .vdc_up(vup), .vdc_low(vlo), .temp(tmp), .sup_5v(sup), .ack_btn(ack),
    .gate_q(gate), .fault_flags_q(flags), .error_n_q(err));
  task results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wait_flags(input logic [3:0] m, input int lim);
    int i;
    for (i = 0; i < lim && (flags & m) !== m; i++) begin @(posedge clk); #1; end
    if (i == lim) begin n_mismatch++; results(); end
  endtask
  task push;
    @(posedge clk) press <= 1'b1;
    tick(3);
    press <= 1'b0;
    tick(3);
    #1;
  endtask
  initial begin
    tick(2);
    #1 `CHK({flags, err, gate}, 9'h010)
    @(posedge clk) rst_n <= 1'b1;
    foreach (rows[k]) begin
      @(posedge clk) dm <= rows[k][8];
      cmd <= rows[k][7:4];
      tick(3);
      #1 `CHK(gate, rows[k][3:0])
    end
    @(posedge clk) dm <= 1'b0;
    cmd <= 4'h5;
    sh <= 1'b1;
    cur <= 12'h12D;
    wait_flags(4'h1, 700);
    `CHK({flags, err, gate}, {4'h1, 1'b0, gfs_pkg::GATE_BLOCKED})
    push();
    `CHK(err, 1'b0)
    @(posedge clk) cur <= 12'h12C;
    tick(340);
    #1 `CHK(err, 1'b0)
    push();
    `CHK({flags, err, gate}, 9'h015)
    @(posedge clk) vup <= 12'h1C3;
    wait_flags(4'h2, 700);
    `CHK(gate, gfs_pkg::GATE_SHORT)
    @(posedge clk) vup <= 12'h000;
    sh <= 1'b0;
    tick(340);
    push();
    `CHK({flags, err}, 5'h01)
    @(posedge clk) vlo <= 12'h1C3;
    wait_flags(4'h2, 700);
    `CHK({flags, err, gate}, {4'h2, 1'b0, gfs_pkg::GATE_BLOCKED})
    @(posedge clk) vlo <= 12'h000;
    tick(340);
    push();
    `CHK({flags, err}, 5'h01)
    @(posedge clk) tmp <= 12'h05B;
    sup <= 12'h1C1;
    wait_flags(4'hC, 50010);
    `CHK({flags, gate}, 8'hC0)
    results();
  end
endmodule
